// >>> hdl/ccse_encoder.v
// ccse_encoder.v: builds the completion status and error bytes, the
// stream error address and count, and the log bookkeeping at command end.
// assumes the command engine gives one cmp_valid pulse per completion with
// its events held valid in that cycle, and a power-on reset on por.
//
// What this block does
// - status byte: busy,ready,fault/stream,drq,align,sense,err
// - alignment bit needs support, mode, clean misaligned write
// - other error hides alignment error
// - every misaligned write logged while log has room
// - stream bit on error in continuous stream
// - stream error gives first lba and count
// - continuous stream error: stream set, err cleared, logged
// - fault condition aborts all but request-sense-ext
// - request-sense-ext under fault may succeed with sense
// - fault bit cleared only by power cycle
// - error summary equals or of error byte outside continuous stream errors
// - sense bit when supported, enabled and present
// - sense bit meaningless when sense off
// - error byte: crc,unc,idnf,abort,timeout; others obsolete
// - abort bit follows command aborted
// - out-of-range sets exactly one of idnf/abort
// - missing user address sets idnf, clears abort
// - crc bit on dma crc error, forces abort
// - timeout bit only for supported stream timeout
// - uncorrectable bit follows data error
// - ncq tag reported in count on error
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "ccse_map.vh"

module ccse_encoder #(
    parameter LOG_DEPTH = 255,
    parameter TAG_W = 5
) (
    // clock and resets
    input wire clk,
    input wire rst,
    input wire por,
    // axi4-lite write address and data
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // transport status bits
    input wire tr_busy,
    input wire tr_ready,
    input wire tr_drq,
    // completion strobe and command kind
    input wire cmp_valid,
    input wire cmd_write,
    input wire cmd_stream_rd,
    input wire cmd_stream_wr,
    input wire cmd_continuous,
    input wire cmd_req_sense_ext,
    input wire cmd_ncq,
    input wire cmd_integrity,
    input wire [TAG_W-1:0] ncq_tag,
    // completion events
    input wire ev_crc,
    input wire ev_unc,
    input wire ev_not_found,
    input wire ev_out_of_range,
    input wire ev_abort,
    input wire ev_timeout,
    input wire ev_misalign,
    input wire ev_sense,
    input wire [47:0] ev_err_lba,
    input wire [15:0] ev_err_count,
    // device integrity condition
    input wire fault_cond,
    // completion outputs
    output reg [7:0] status_q,
    output reg [7:0] error_q,
    output reg [47:0] lba_q,
    output reg [15:0] count_q,
    output reg sense_hw_fail_q,
    output reg done_q,
    // log write pulses
    output reg mis_log_wr_q,
    output reg rd_strlog_wr_q,
    output reg wr_strlog_wr_q
);

    // ----
    // state
    // ----
    // rst spares fault_q
    // por alone clears it
    reg [`CCSE_CF_WIDTH-1:0] cfg_q; // software configuration
    reg fault_q; // sticky device fault
    reg [7:0] mis_cnt_q; // misalignment log entries used
    reg [7:0] rd_strlog_q; // last error byte saved for read stream
    reg [7:0] wr_strlog_q; // last error byte saved for write stream
    reg aw_full_q; // write address held
    reg w_full_q; // write data held
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    // config fields
    // one bit each, mode has two
    // all low after rst
    wire lps_sup = cfg_q[`CCSE_CF_LPS_SUP];
    wire mis_sup = cfg_q[`CCSE_CF_MIS_SUP];
    wire [1:0] amode = cfg_q[`CCSE_CF_AMODE_HI:`CCSE_CF_AMODE_LO];
    wire sense_sup = cfg_q[`CCSE_CF_SENSE_SUP];
    wire sense_en = cfg_q[`CCSE_CF_SENSE_EN];
    wire strm_sup = cfg_q[`CCSE_CF_STRM_SUP];
    wire dfsense_sup = cfg_q[`CCSE_CF_DFSENSE_SUP];
    wire oor_abrt = cfg_q[`CCSE_CF_OOR_ABRT];

    // ----
    // completion encoding (combinational)
    // ----
    // used in the cmp_valid cycle
    // fault beats every error event
    // stream error hides summary
    reg fault_d;
    reg fault_path; // this command runs under the fault condition
    reg fault_sense_ok; // request-sense-ext answered with hw failure
    reg stream_cmd;
    reg [7:0] err_d;
    reg abort_d;
    reg idnf_d;
    reg any_err;
    reg stream_err;
    reg align_d;
    reg sense_d;
    reg [7:0] status_d;
    reg mis_log_d;

    // fault and error byte decisions
    always @* begin
        // fault only latches on a command that touches user data
        fault_d = fault_q | (cmp_valid & fault_cond & cmd_integrity);
        fault_path = fault_d;
        fault_sense_ok = fault_path & cmd_req_sense_ext & sense_sup & dfsense_sup;
        stream_cmd = cmd_stream_rd | cmd_stream_wr;
        // not-found wins over a plain abort; crc always aborts
        idnf_d = ev_not_found | (ev_out_of_range & ~oor_abrt);
        abort_d = ev_crc | ((ev_abort | (ev_out_of_range & oor_abrt)) & ~ev_not_found);
        err_d = 8'h00;
        if (fault_path) begin
            if (!fault_sense_ok) begin
                // every other command is aborted with the fault bit
                err_d[`CCSE_ER_ABRT] = 1'b1;
            end
        end else begin
            err_d[`CCSE_ER_CRC] = ev_crc;
            err_d[`CCSE_ER_UNC] = ev_unc;
            err_d[`CCSE_ER_IDNF] = idnf_d;
            err_d[`CCSE_ER_ABRT] = abort_d;
            err_d[`CCSE_ER_CCTO] = ev_timeout & strm_sup & stream_cmd;
        end
        // obsolete bits 5, 3 and 1 stay low
        any_err = |err_d;
        stream_err = stream_cmd & cmd_continuous & any_err & ~fault_path;
        // clean misaligned write only, with all support on
        align_d = lps_sup & mis_sup & ((amode == `CCSE_AMODE_A) | (amode == `CCSE_AMODE_B))
                  & cmd_write & ev_misalign & ~any_err;
        // sense data reported only when supported and enabled
        sense_d = sense_sup & sense_en & (ev_sense | fault_sense_ok);
        mis_log_d = cmp_valid & cmd_write & ev_misalign & (mis_cnt_q < LOG_DEPTH[7:0]);
    end

    // status byte assembly
    // bit 4 stays low
    // bit 5 shared by fault, stream
    always @* begin
        status_d = 8'h00;
        status_d[`CCSE_ST_BUSY] = tr_busy;
        status_d[`CCSE_ST_READY] = tr_ready;
        status_d[`CCSE_ST_DREQ] = tr_drq;
        status_d[`CCSE_ST_FAULT] = (fault_path & ~fault_sense_ok) | stream_err;
        status_d[`CCSE_ST_ALIGN] = align_d;
        status_d[`CCSE_ST_SENSE] = sense_d;
        // summary follows the error byte, except for a continuous stream
        status_d[`CCSE_ST_ERR] = any_err & ~stream_err;
    end

    // ----
    // completion registers
    // ----
    // record holds until next completion
    // log pulses last one cycle
    // log count saturates at depth
    // fault bit: only power-on clears it, never rst or a command
    always @(posedge clk) begin
        if (por) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_d;
        end
    end

    // transport bits follow every cycle; the rest update at completion
    always @(posedge clk) begin
        if (rst) begin
            status_q <= 8'h00;
            error_q <= 8'h00;
            lba_q <= 48'h0;
            count_q <= 16'h0;
            sense_hw_fail_q <= 1'b0;
            done_q <= 1'b0;
            mis_log_wr_q <= 1'b0;
            rd_strlog_wr_q <= 1'b0;
            wr_strlog_wr_q <= 1'b0;
            mis_cnt_q <= 8'h00;
            rd_strlog_q <= 8'h00;
            wr_strlog_q <= 8'h00;
        end else begin
            done_q <= cmp_valid;
            mis_log_wr_q <= mis_log_d;
            rd_strlog_wr_q <= cmp_valid & stream_err & cmd_stream_rd;
            wr_strlog_wr_q <= cmp_valid & stream_err & cmd_stream_wr;
            status_q[`CCSE_ST_BUSY] <= tr_busy;
            status_q[`CCSE_ST_READY] <= tr_ready;
            status_q[`CCSE_ST_DREQ] <= tr_drq;
            if (mis_log_d) begin
                mis_cnt_q <= mis_cnt_q + 8'h01;
            end
            if (cmp_valid) begin
                status_q <= status_d;
                error_q <= err_d;
                sense_hw_fail_q <= fault_sense_ok;
                if (stream_err) begin
                    // first bad sector and run length
                    lba_q <= ev_err_lba;
                    count_q <= ev_err_count;
                    if (cmd_stream_rd) begin
                        rd_strlog_q <= err_d;
                    end
                    if (cmd_stream_wr) begin
                        wr_strlog_q <= err_d;
                    end
                end else if (cmd_ncq && any_err) begin
                    lba_q <= ev_err_lba;
                    count_q <= {{(16-TAG_W){1'b0}}, ncq_tag};
                end else begin
                    lba_q <= 48'h0;
                    count_q <= 16'h0;
                end
            end
        end
    end

    // ----
    // axi4-lite write channel
    // ----
    // a held channel drops ready
    // freed when response rises
    // pending response stalls writes
    assign s_axi_awready = ~aw_full_q;
    assign s_axi_wready = ~w_full_q;

    // byte-lane merge of a write into the config register
    function [31:0] ccse_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] strb;
        integer i;
        begin
            ccse_merge = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    ccse_merge[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    wire [31:0] cfg_ext = {{(32-`CCSE_CF_WIDTH){1'b0}}, cfg_q};
    wire [31:0] cfg_new = ccse_merge(cfg_ext, w_data_q, w_strb_q);
    wire wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;

    // address and data taken in either order, response after both
    always @(posedge clk) begin
        if (rst) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CCSE_RESP_OKAY;
            cfg_q <= `CCSE_CF_RESET;
        end else begin
            if (s_axi_awvalid && !aw_full_q) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full_q) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // only config is writable; read-only words ignore writes
                if (aw_addr_q[7:2] == `CCSE_OFF_CONFIG >> 2) begin
                    cfg_q <= cfg_new[`CCSE_CF_WIDTH-1:0];
                    s_axi_bresp <= `CCSE_RESP_OKAY;
                end else if (aw_addr_q[7:2] <= `CCSE_OFF_STRLOG >> 2) begin
                    s_axi_bresp <= `CCSE_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `CCSE_RESP_DECERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----
    // axi4-lite read channel
    // ----
    // arready low while data waits
    // unmapped reads zero
    // with a decode error
    assign s_axi_arready = ~s_axi_rvalid;

    // one read at a time; data answered the cycle after arvalid is taken
    always @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `CCSE_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `CCSE_RESP_OKAY;
            if (s_axi_araddr[7:2] == `CCSE_OFF_STATUS >> 2) begin
                s_axi_rdata <= {24'h0, status_q};
            end else if (s_axi_araddr[7:2] == `CCSE_OFF_ERROR >> 2) begin
                s_axi_rdata <= {24'h0, error_q};
            end else if (s_axi_araddr[7:2] == `CCSE_OFF_CONFIG >> 2) begin
                s_axi_rdata <= cfg_ext;
            end else if (s_axi_araddr[7:2] == `CCSE_OFF_LBA_LO >> 2) begin
                s_axi_rdata <= lba_q[31:0];
            end else if (s_axi_araddr[7:2] == `CCSE_OFF_LBA_HI >> 2) begin
                s_axi_rdata <= {16'h0, lba_q[47:32]};
            end else if (s_axi_araddr[7:2] == `CCSE_OFF_COUNT >> 2) begin
                s_axi_rdata <= {16'h0, count_q};
            end else if (s_axi_araddr[7:2] == `CCSE_OFF_LOGINFO >> 2) begin
                s_axi_rdata <= {23'h0, fault_q, mis_cnt_q};
            end else if (s_axi_araddr[7:2] == `CCSE_OFF_STRLOG >> 2) begin
                s_axi_rdata <= {16'h0, wr_strlog_q, rd_strlog_q};
            end else begin
                // unmapped word
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= `CCSE_RESP_DECERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// >>> hdl/ccse_map.vh
// ccse_map.vh: register offsets, field positions and reset values of the
// completion status encoder. definitions only, included by bare name.
`ifndef CCSE_MAP_VH
`define CCSE_MAP_VH

// ----
// register byte offsets on the axi4-lite slave
// ----
`define CCSE_OFF_STATUS 8'h00
`define CCSE_OFF_ERROR 8'h04
`define CCSE_OFF_CONFIG 8'h08
`define CCSE_OFF_LBA_LO 8'h0c
`define CCSE_OFF_LBA_HI 8'h10
`define CCSE_OFF_COUNT 8'h14
`define CCSE_OFF_LOGINFO 8'h18
`define CCSE_OFF_STRLOG 8'h1c

// ----
// status byte bit positions
// ----
`define CCSE_ST_BUSY 7
`define CCSE_ST_READY 6
`define CCSE_ST_FAULT 5
`define CCSE_ST_DREQ 3
`define CCSE_ST_ALIGN 2
`define CCSE_ST_SENSE 1
`define CCSE_ST_ERR 0

// ----
// error byte bit positions
// ----
`define CCSE_ER_CRC 7
`define CCSE_ER_UNC 6
`define CCSE_ER_IDNF 4
`define CCSE_ER_ABRT 2
`define CCSE_ER_CCTO 0

// ----
// config register fields and reset value
// ----
`define CCSE_CF_LPS_SUP 0
`define CCSE_CF_MIS_SUP 1
`define CCSE_CF_AMODE_LO 2
`define CCSE_CF_AMODE_HI 3
`define CCSE_CF_SENSE_SUP 4
`define CCSE_CF_SENSE_EN 5
`define CCSE_CF_STRM_SUP 6
`define CCSE_CF_DFSENSE_SUP 7
`define CCSE_CF_OOR_ABRT 8
`define CCSE_CF_WIDTH 9
`define CCSE_CF_RESET 9'h000

// alignment reporting codes that enable the alignment bit
`define CCSE_AMODE_A 2'h1
`define CCSE_AMODE_B 2'h2

// axi response codes
`define CCSE_RESP_OKAY 2'h0
`define CCSE_RESP_DECERR 2'h3

`endif

// >>> test/ccse_encoder_assertions.sv
// ccse_encoder_assertions.sv: port-level checks of the completion encoder.
// assumes a bind onto ccse_encoder; fault state is rebuilt here from its ports.
`timescale 1ns/10ps
module ccse_checker (
    // clock and resets
    input clk,
    input rst,
    input por,
    // completion inputs
    input cmp_valid,
    input cmd_write,
    input cmd_stream_rd,
    input cmd_stream_wr,
    input cmd_continuous,
    input cmd_req_sense_ext,
    input cmd_integrity,
    input ev_crc,
    input ev_unc,
    input ev_not_found,
    input ev_out_of_range,
    input ev_abort,
    input ev_misalign,
    input [47:0] ev_err_lba,
    input fault_cond,
    // transport bits
    input tr_busy,
    input tr_ready,
    input tr_drq,
    // outputs watched
    input [7:0] status_q,
    input [7:0] error_q,
    input [47:0] lba_q,
    input done_q,
    input mis_log_wr_q
);
    // ----
    // fault state as seen from the ports
    // ----
    reg flt_q; // sticky fault
    reg aff_q; // last completion ran under fault
    wire flt_now = flt_q | (cmp_valid & fault_cond & cmd_integrity);
    // only power-on reset clears it, a plain reset does not
    always @(posedge clk) begin
        if (por) begin
            flt_q <= 1'b0;
            aff_q <= 1'b0;
        end else begin
            flt_q <= flt_now;
            aff_q <= flt_now;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----
    // assertions
    // ----
    done_pulse_a:
        assert property (1'b1 |=> done_q == $past(cmp_valid)) else $error("done pulse wrong");
    transport_copy_a:
        assert property (!$past(rst) |-> status_q[7] == $past(tr_busy)
            && status_q[6] == $past(tr_ready) && status_q[3] == $past(tr_drq))
        else $error("transport bit not copied");
    err_summary_a:
        assert property (done_q && !aff_q && !status_q[5] |-> status_q[0] == (error_q != 8'h00))
        else $error("error summary wrong");
    crc_abort_a:
        assert property (done_q && error_q[7] |-> error_q[2]) else $error("crc without abort");
    found_no_abort_a:
        assert property (done_q && !aff_q && $past(ev_not_found) && !$past(ev_crc)
            |-> error_q[4] && !error_q[2]) else $error("not found also aborted");
    range_one_bit_a:
        assert property (done_q && !aff_q && $past(ev_out_of_range) && !$past(ev_not_found)
            && !$past(ev_crc) && !$past(ev_abort) |-> error_q[4] ^ error_q[2])
        else $error("out of range not one bit");
    uncor_follow_a:
        assert property (done_q && !aff_q |-> error_q[6] == $past(ev_unc))
        else $error("uncorrectable bit wrong");
    align_clean_a:
        assert property (done_q && status_q[2] |-> error_q == 8'h00) else $error("align with error");
    fault_abort_a:
        assert property (done_q && aff_q && !$past(cmd_req_sense_ext)
            |-> status_q[5] && error_q == 8'h04) else $error("fault not aborted");
    stream_err_a:
        assert property (done_q && !aff_q && $past(cmd_continuous)
            && ($past(cmd_stream_rd) || $past(cmd_stream_wr)) && error_q != 8'h00
            |-> status_q[5] && !status_q[0] && lba_q == $past(ev_err_lba))
        else $error("stream error report wrong");
    timeout_stream_a:
        assert property (done_q && error_q[0] |-> $past(cmd_stream_rd) || $past(cmd_stream_wr))
        else $error("timeout on non stream");
    mis_log_a:
        assert property (mis_log_wr_q |-> done_q && $past(ev_misalign) && $past(cmd_write))
        else $error("stray log entry");
endmodule
bind ccse_encoder ccse_checker chk_u (
    .clk, .rst, .por, .cmp_valid, .cmd_write, .cmd_stream_rd, .cmd_stream_wr,
    .cmd_continuous, .cmd_req_sense_ext, .cmd_integrity, .ev_crc, .ev_unc, .ev_not_found,
    .ev_out_of_range, .ev_abort, .ev_misalign, .ev_err_lba, .fault_cond, .tr_busy,
    .tr_ready, .tr_drq, .status_q, .error_q, .lba_q, .done_q, .mis_log_wr_q
);

// >>> test/ccse_host_model.sv
// ccse_host_model.sv: host side that takes each completion record.
// assumes done_q marks the one cycle in which the record is fresh.
`timescale 1ns/10ps
module ccse_host_model (
    // clock
    input wire clk,
    // completion record from the device
    input wire done_q,
    input wire [7:0] status_q,
    input wire [7:0] error_q,
    input wire [47:0] lba_q,
    input wire [15:0] count_q,
    // last record taken
    output reg [15:0] got_se_q,
    output reg [63:0] got_lc_q
);
    // takes the record only in the cycle the pulse stands
    always @(posedge clk) begin
        if (done_q) begin
            got_se_q <= {status_q, error_q};
            got_lc_q <= {lba_q, count_q};
        end
    end
endmodule

// >>> test/tb.sv
// tb.sv: random and corner completions, register access, fault handling.
// assumes ccse_map.vh on the include path and the checker bound in.
`timescale 1ns/10ps
`include "ccse_map.vh"
module tb;
    // ----
    // stimulus and observed signals
    // ----
    localparam LOG_D = 6; // small log so it fills
    localparam LIMIT = 10000; // cycle ceiling
    reg clk = 1'b0, rst = 1'b1, por = 1'b1;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00;
    reg [31:0] wdata = 32'h0, rd;
    reg [2:0] trb = 3'h0; // busy, ready, drq
    reg cv = 1'b0; // completion strobe
    reg [15:0] v = 16'h0000, x; // command kind, events, fault
    reg [4:0] tag = 5'h00;
    reg [47:0] elba = 48'h0;
    reg [15:0] ecnt = 16'h0;
    reg [8:0] cfg = 9'h000;
    reg [1:0] rs;
    wire awready, wready, bvalid, arready, rvalid, hwf, done, mlw, rlw, wlw;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] st, er;
    wire [47:0] lba;
    wire [15:0] cnt, got_se;
    wire [63:0] got_lc;
    integer n_mismatch = 0, samples_checked = 0, cyc = 0, i, mis_n = 0;
    always #25 clk = ~clk;
    ccse_encoder #(.LOG_DEPTH(LOG_D), .TAG_W(5)) dut_u (
        .clk(clk), .rst(rst), .por(por),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .tr_busy(trb[2]), .tr_ready(trb[1]), .tr_drq(trb[0]),
        .cmp_valid(cv), .cmd_write(v[0]), .cmd_stream_rd(v[1]), .cmd_stream_wr(v[2]),
        .cmd_continuous(v[3]), .cmd_req_sense_ext(v[4]), .cmd_ncq(v[5]), .cmd_integrity(v[6]),
        .ncq_tag(tag), .ev_crc(v[7]), .ev_unc(v[8]), .ev_not_found(v[9]),
        .ev_out_of_range(v[10]), .ev_abort(v[11]), .ev_timeout(v[12]), .ev_misalign(v[13]),
        .ev_sense(v[14]), .ev_err_lba(elba), .ev_err_count(ecnt), .fault_cond(v[15]),
        .status_q(st), .error_q(er), .lba_q(lba), .count_q(cnt), .sense_hw_fail_q(hwf),
        .done_q(done), .mis_log_wr_q(mlw), .rd_strlog_wr_q(rlw), .wr_strlog_wr_q(wlw)
    );
    ccse_host_model host_u (
        .clk(clk), .done_q(done), .status_q(st), .error_q(er), .lba_q(lba),
        .count_q(cnt), .got_se_q(got_se), .got_lc_q(got_lc)
    );
    // ----
    // compare, close, watchdog
    // ----
    task chk(input [63:0] seen, input [63:0] want, input [8*8-1:0] what);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== want) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch %0s expected %h seen %h", what, want, seen);
            end
        end
    endtask
    task end_sim;
        begin
            $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
            if (n_mismatch == 0 && samples_checked > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // cycle ceiling, transport bits wander meanwhile
    always @(posedge clk) begin
        cyc <= cyc + 1;
        trb <= 3'($urandom);
        if (cyc == LIMIT) begin
            n_mismatch = n_mismatch + 1;
            end_sim;
        end
    end
    // ----
    // bus tasks: ready sampled mid-cycle, acted on at the edge
    // ----
    task axi_wr(input [7:0] a, input [31:0] d, output [1:0] r);
        reg ah, wh, bh;
        begin
            awaddr <= a;
            wdata <= d;
            {awvalid, wvalid, bready} <= 3'b111;
            bh = 1'b0;
            while (!bh) begin
                @(negedge clk);
                {ah, wh, bh, r} = {awvalid & awready, wvalid & wready, bvalid, bresp};
                @(posedge clk);
                if (ah) awvalid <= 1'b0;
                if (wh) wvalid <= 1'b0;
            end
            bready <= 1'b0;
        end
    endtask
    task axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
        reg ah, dh;
        begin
            araddr <= a;
            {arvalid, rready} <= 2'b11;
            dh = 1'b0;
            while (!dh) begin
                @(negedge clk);
                {ah, dh, d, r} = {arvalid & arready, rvalid, rdata, rresp};
                @(posedge clk);
                if (ah) arvalid <= 1'b0;
            end
            rready <= 1'b0;
        end
    endtask
    // expected {status, error} of a completion outside the fault state
    function [15:0] f_exp(input [15:0] c, input [8:0] g);
        reg [7:0] s, e;
        begin
            e = 8'h00;
            e[7] = c[7];
            e[6] = c[8];
            e[4] = c[9] | (c[10] & ~g[8]);
            e[2] = c[7] | ((c[11] | (c[10] & g[8])) & ~c[9]);
            e[0] = c[12] & g[6] & (c[1] | c[2]);
            s = 8'h00;
            s[5] = (c[1] | c[2]) & c[3] & (e != 8'h00);
            s[0] = (e != 8'h00) & ~s[5];
            s[2] = g[0] & g[1] & (g[3:2] == `CCSE_AMODE_A || g[3:2] == `CCSE_AMODE_B)
                & c[0] & c[13] & (e == 8'h00);
            s[1] = g[4] & g[5] & c[14];
            f_exp = {s, e};
        end
    endfunction
    // one completion, checked at the pulse and at the host
    task cmp(input [15:0] c, input fl);
        reg [15:0] e;
        reg lg;
        begin
            v <= c;
            tag <= 5'($urandom);
            elba <= {16'($urandom), $urandom};
            ecnt <= 16'($urandom);
            cv <= 1'b1;
            @(posedge clk);
            cv <= 1'b0;
            e = f_exp(c, cfg);
            lg = c[0] & c[13] & (mis_n < LOG_D);
            @(negedge clk);
            chk(done, 1'b1, "done");
            chk(mlw, lg, "mislog");
            chk({rlw, wlw}, {e[13] & c[1], e[13] & c[2]}, "loglen");
            mis_n = mis_n + lg;
            @(posedge clk);
            @(negedge clk);
            if (!fl) begin
                chk(got_se & 16'h37ff, e, "st_err");
                chk(got_lc, e[13] ? {elba, ecnt} : (c[5] && e[7:0] != 8'h00)
                    ? {elba, 11'h0, tag} : 64'h0, "lba_cnt");
            end
            @(posedge clk);
        end
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        i = $urandom(32'h687b91b8);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        @(posedge clk);
        // reset values, read-only and unmapped places
        axi_rd(`CCSE_OFF_CONFIG, rd, rs);
        chk(rd, 32'h0, "cfg_rst");
        axi_wr(`CCSE_OFF_STATUS, 32'hff, rs);
        chk(rs, `CCSE_RESP_OKAY, "ro_wr");
        axi_rd(`CCSE_OFF_STATUS, rd, rs);
        chk(rd & 32'hffffff37, 32'h0, "ro_keep");
        axi_rd(8'h20, rd, rs);
        chk({rd, rs}, {32'h0, `CCSE_RESP_DECERR}, "unmapped");
        // random completions under changing settings
        for (i = 0; i < 300; i = i + 1) begin
            if (i % 25 == 0) begin
                cfg = 9'($urandom) | ((i % 50 == 0) ? 9'h003 : 9'h000);
                axi_wr(`CCSE_OFF_CONFIG, {23'h0, cfg}, rs);
                axi_rd(`CCSE_OFF_CONFIG, rd, rs);
                chk(rd, {23'h0, cfg}, "cfg");
            end
            x = 16'($urandom) & 16'($urandom) & 16'h7f80;
            x[6:0] = 7'($urandom);
            if (x[1]) x[2] = 1'b0;
            if (x[1] | x[2]) x[5] = 1'b0;
            cmp(x, 1'b0);
        end
        axi_rd(`CCSE_OFF_LOGINFO, rd, rs);
        chk(rd, mis_n, "mis_cnt");
        // fault state: abort, sticky, sense request both ways
        cfg = 9'h0b0;
        axi_wr(`CCSE_OFF_CONFIG, {23'h0, cfg}, rs);
        cmp(16'h8041, 1'b1);
        chk({got_se[13], got_se[8], got_se[7:0]}, 10'h304, "fault");
        cmp(16'h0001, 1'b1);
        chk({got_se[13], got_se[7:0]}, 9'h104, "sticky");
        cmp(16'h0010, 1'b1);
        chk({got_se[13], got_se[9], got_se[7:0], hwf}, 11'h201, "rse_ok");
        cfg = 9'h030;
        axi_wr(`CCSE_OFF_CONFIG, {23'h0, cfg}, rs);
        cmp(16'h0010, 1'b1);
        chk({got_se[13], got_se[7:0]}, 9'h104, "rse_abrt");
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        axi_rd(`CCSE_OFF_LOGINFO, rd, rs);
        chk(rd[8], 1'b1, "flt_rst");
        cmp(16'h0002, 1'b1);
        chk({got_se[13], got_se[7:0]}, 9'h104, "flt_keep");
        rst <= 1'b1;
        por <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        @(posedge clk);
        axi_rd(`CCSE_OFF_LOGINFO, rd, rs);
        chk(rd[8], 1'b0, "flt_por");
        end_sim;
    end
endmodule
